// ==== inc/tec_pkg.sv ====
package tec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_RCA   = 8'h08;
  localparam logic [7:0] ADDR_RCB   = 8'h0c;
  localparam logic [7:0] ADDR_PORT  = 8'h10;
  localparam logic [7:0] ADDR_BITOP = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_MI = 2;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_PEND_A  = 4;
  localparam int CTRL_IRQEN_A = 5;
  localparam int CTRL_PEND_B  = 6;
  localparam int CTRL_IRQEN_B = 7;
  localparam int CTRL_FAST    = 8;
  localparam int CTRL_WIDTH   = 9;

  // bit operation register fields
  localparam int BITOP_SET    = 3;
  localparam int BITOP_IDX_HI = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and timing
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [7:0]  PORT_RST   = 8'h00;
  localparam logic [3:0]  INSTR_DIV  = 4'ha;
  localparam logic [3:0]  DIV_LAST   = INSTR_DIV - 4'h1;
  localparam int          PWM_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // control register image
  typedef struct packed {
    logic       fast_select;
    logic       irq_en_b;
    logic       pend_b;
    logic       irq_en_a;
    logic       pend_a;
    logic       mode_sel_bit_hi;
    logic       mode_sel_bit_mid;
    logic       mode_sel_bit_lo;
    logic       run_or_underflow_flag;
  } tec_ctrl_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tec_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tec_apb_rsp_t;

  // edge detector state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } tec_sync_t;

endpackage

// ==== rtl/tec_pin_sync.sv ====
module tec_pin_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  tec_pkg::tec_sync_t st_r;
  tec_pkg::tec_sync_t st_nxt;

  // two-stage sync, then edge detect on stage two and three
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pin;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.s3;
    st_nxt.fall = ~st_r.s2 & st_r.s3;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign rise = st_r.rise;
  assign fall = st_r.fall;

endmodule

// ==== rtl/tec_timer.sv ====
// Functional notes
// - event mode: timer decrements on synchronised edges of timer_io_pin
// - mode bits choose rising or falling count edge in event mode
// - event mode underflow sets pend_a; interrupt A when irq_en_a set
// - event mode rising timer_in_pin edge sets pend_b; interrupt B with irq_en_b
// - event mode drives no output on timer_io_pin
// - capture mode counts down continuously at selected rate
// - selected pin edges copy count into reload_capture_a / reload_capture_b
// - capture edge polarity chosen separately per pin by mode bits
// - capture triggers set pend_a / pend_b; enables gate interrupts
// - capture mode underflow sets run_or_underflow_flag; irq_en_a enables it
// - reading capture registers leaves the count running undisturbed
// - in pulse-width and event modes run_or_underflow_flag starts/stops timer
// - interrupt enable one enables, zero suppresses its interrupt
// - port bit operation during a toggle can restore the pre-toggle level
// - control register accepts any access in every mode at any speed
// - pulse-width mode: first underflow reloads from a, then alternates from b
// - fast_select one clocks from fast clock, zero from instruction clock
//
// Our own choices: the register offsets and register access over APB.
module tec_timer (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire tec_pkg::tec_apb_req_t apb_req,
  output tec_pkg::tec_apb_rsp_t      apb_rsp,
  input  wire logic                  timer_io_pin,
  input  wire logic                  timer_in_pin,
  output logic                       timer_io_out,
  output logic                       timer_io_oe_n,
  output logic [7:0]                 shared_port_out,
  output logic                       irq_a,
  output logic                       irq_b
);

  typedef struct packed {
    tec_pkg::tec_ctrl_t    ctrl;
    logic [15:0]           count;
    logic [15:0]           reload_capture_a;
    logic [15:0]           reload_capture_b;
    logic [7:0]            port_data;
    logic [7:0]            port_snap;
    logic [3:0]            div;
    logic                  next_from_b;
    logic                  out_oe_n;
    logic                  irq_a;
    logic                  irq_b;
    tec_pkg::tec_apb_rsp_t rsp;
  } tec_state_t;

  tec_state_t st_r;
  tec_state_t st_nxt;

  logic io_rise;
  logic io_fall;
  logic in_rise;
  logic in_fall;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  tec_pin_sync u_sync_io (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .pin      (timer_io_pin),
    .rise     (io_rise),
    .fall     (io_fall)
  );

  tec_pin_sync u_sync_in (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .pin      (timer_in_pin),
    .rise     (in_rise),
    .fall     (in_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic        mode_event;
  logic        mode_capture;
  logic        mode_pwm;
  logic        tick;
  logic        count_en;
  logic        underflow;
  logic        edge_a;
  logic        edge_b;
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [31:0] rdata;
  logic [7:0]  bit_mask;
  logic [2:0]  mode_sel;
  logic        ctrl_wr;
  logic        bitop_set;
  logic [2:0]  bitop_idx;
  logic        cap_a;
  logic        cap_b;
  logic        ev_b;
  logic        irq_a_src;

  always_comb begin
    st_nxt = st_r;

    // mode decode; every code with the middle bit set is a capture mode
    mode_sel     = {st_r.ctrl.mode_sel_bit_hi, st_r.ctrl.mode_sel_bit_mid,
                    st_r.ctrl.mode_sel_bit_lo};
    mode_event   = 1'b0;
    mode_capture = 1'b0;
    mode_pwm     = 1'b0;
    case (mode_sel)
      3'b000, 3'b001: begin
        mode_event = 1'b1;
      end
      3'b100, 3'b101: begin
        mode_pwm = 1'b1;
      end
      default: begin
        mode_capture = 1'b1;
      end
    endcase

    // instruction-cycle tick from a free-running divider, so the first
    // slow tick after a start can come early by up to one period
    st_nxt.div = (st_r.div == tec_pkg::DIV_LAST) ? 4'h0 : st_r.div + 4'h1;
    tick       = st_r.ctrl.fast_select | (st_r.div == tec_pkg::DIV_LAST);

    // edge choice per pin; the hi bit picks the pin B edge in capture only,
    // event mode always takes rising pin B edges
    edge_a = st_r.ctrl.mode_sel_bit_lo ? io_fall : io_rise;
    edge_b = st_r.ctrl.mode_sel_bit_hi ? in_fall : in_rise;
    cap_a  = mode_capture & edge_a;
    cap_b  = mode_capture & edge_b;
    ev_b   = mode_event & in_rise;

    if (mode_event) begin
      count_en = st_r.ctrl.run_or_underflow_flag & edge_a;
    end else if (mode_capture) begin
      count_en = tick;
    end else begin
      count_en = st_r.ctrl.run_or_underflow_flag & tick;
    end
    underflow = count_en & (st_r.count == 16'h0000);

    // a count write further down wins over this decrement
    if (count_en) begin
      st_nxt.count = st_r.count - 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, no wait state: pready rises in the first access cycle
    setup  = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable & st_r.rsp.pready;
    wr     = access & apb_req.pwrite;
    // control writes that start a stopped timer also restart the reload order below
    ctrl_wr = wr & (apb_req.paddr == tec_pkg::ADDR_CTRL);
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (apb_req.paddr)
      tec_pkg::ADDR_CTRL:  rdata = {23'h000000, st_r.ctrl};
      tec_pkg::ADDR_COUNT: rdata = {16'h0000, st_r.count};
      tec_pkg::ADDR_RCA:   rdata = {16'h0000, st_r.reload_capture_a};
      tec_pkg::ADDR_RCB:   rdata = {16'h0000, st_r.reload_capture_b};
      tec_pkg::ADDR_PORT:  rdata = {24'h000000, st_r.port_data};
      tec_pkg::ADDR_BITOP: rdata = 32'h0000_0000;
      default:             mapped = 1'b0;
    endcase
    // bit operation: bit 3 picks set or clear, bits 2:0 the port bit
    bitop_set = apb_req.pwdata[tec_pkg::BITOP_SET];
    bitop_idx = apb_req.pwdata[tec_pkg::BITOP_IDX_HI:0];
    bit_mask  = 8'h01 << bitop_idx;

    st_nxt.rsp.pready = setup;
    if (setup) begin
      st_nxt.rsp.prdata  = rdata;
      st_nxt.rsp.pslverr = ~mapped;
      st_nxt.port_snap   = st_r.port_data;
    end

    if (wr) begin
      case (apb_req.paddr)
        tec_pkg::ADDR_CTRL: begin
          st_nxt.ctrl = apb_req.pwdata[tec_pkg::CTRL_WIDTH-1:0];
        end
        tec_pkg::ADDR_COUNT: begin
          st_nxt.count = apb_req.pwdata[15:0];
        end
        tec_pkg::ADDR_RCA: begin
          st_nxt.reload_capture_a = apb_req.pwdata[15:0];
        end
        tec_pkg::ADDR_RCB: begin
          st_nxt.reload_capture_b = apb_req.pwdata[15:0];
        end
        tec_pkg::ADDR_PORT: begin
          st_nxt.port_data = apb_req.pwdata[7:0];
        end
        tec_pkg::ADDR_BITOP: begin
          // read-modify-write from the setup snapshot
          // a toggle of bit 0 between setup and access is lost
          if (bitop_set) begin
            st_nxt.port_data = st_r.port_snap | bit_mask;
          end else begin
            st_nxt.port_data = st_r.port_snap & ~bit_mask;
          end
        end
        default: begin
          st_nxt.port_data = st_r.port_data;
        end
      endcase
    end

    // restart of the timer starts a fresh reload sequence
    if (ctrl_wr && apb_req.pwdata[tec_pkg::CTRL_RUN] && !st_r.ctrl.run_or_underflow_flag) begin
      st_nxt.next_from_b = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // hardware events; sets win over any clear written in this cycle
    if (mode_capture) begin
      // count wraps through ffff here; the underflow only raises the flag
      if (cap_a) begin
        st_nxt.reload_capture_a = st_r.count;
        st_nxt.ctrl.pend_a      = 1'b1;
      end
      if (cap_b) begin
        st_nxt.reload_capture_b = st_r.count;
        st_nxt.ctrl.pend_b      = 1'b1;
      end
      if (underflow) begin
        st_nxt.ctrl.run_or_underflow_flag = 1'b1;
      end
    end else begin
      if (underflow) begin
        // alternate reloads, first one from a
        if (st_r.next_from_b) begin
          st_nxt.count       = st_r.reload_capture_b;
          st_nxt.next_from_b = 1'b0;
          if (mode_pwm) begin
            st_nxt.ctrl.pend_b = 1'b1;
          end
        end else begin
          st_nxt.count       = st_r.reload_capture_a;
          st_nxt.next_from_b = 1'b1;
        end
        if (mode_event || !st_r.next_from_b) begin
          st_nxt.ctrl.pend_a = 1'b1;
        end
        // the toggle lands on top of any port write in this cycle
        if (mode_pwm && st_r.ctrl.mode_sel_bit_lo) begin
          st_nxt.port_data[tec_pkg::PWM_BIT] = ~st_nxt.port_data[tec_pkg::PWM_BIT];
        end
      end
      if (ev_b) begin
        st_nxt.ctrl.pend_b = 1'b1;
      end
    end

    // output driven only for pulse-width toggle mode
    st_nxt.out_oe_n = ~(mode_pwm & st_r.ctrl.mode_sel_bit_lo);

    ////////////////////////////////////////////////////////////////////////
    // interrupt outputs from the next flags, so flag and irq move on one edge
    // capture mode: interrupt A covers both pin capture and underflow
    irq_a_src    = st_nxt.ctrl.pend_a |
                   (st_nxt.ctrl.mode_sel_bit_mid & st_nxt.ctrl.run_or_underflow_flag);
    st_nxt.irq_a = st_nxt.ctrl.irq_en_a & irq_a_src;
    st_nxt.irq_b = st_nxt.ctrl.irq_en_b & st_nxt.ctrl.pend_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r                  <= '0;
      st_r.count            <= tec_pkg::COUNT_RST;
      st_r.reload_capture_a <= tec_pkg::RELOAD_RST;
      st_r.reload_capture_b <= tec_pkg::RELOAD_RST;
      st_r.port_data        <= tec_pkg::PORT_RST;
      // pin released after reset, no interrupt pending
      st_r.out_oe_n         <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign apb_rsp         = st_r.rsp;
  assign timer_io_out    = st_r.port_data[tec_pkg::PWM_BIT];
  assign timer_io_oe_n   = st_r.out_oe_n;
  assign shared_port_out = st_r.port_data;
  assign irq_a           = st_r.irq_a;
  assign irq_b           = st_r.irq_b;

endmodule

// ==== tb/tec_timer_sva.sv ====
module tec_timer_sva (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire tec_pkg::tec_apb_req_t apb_req,
  input wire tec_pkg::tec_apb_rsp_t apb_rsp,
  input wire logic                  timer_io_pin,
  input wire logic                  timer_in_pin,
  input wire logic                  timer_io_out,
  input wire logic                  timer_io_oe_n,
  input wire logic [7:0]            shared_port_out,
  input wire logic                  irq_a,
  input wire logic                  irq_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence setup_s;
    clk_en && apb_req.psel && !apb_req.penable;
  endsequence
  sequence wr_s;
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_setup_ready: assert property (setup_s |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_once: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  a_ready_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (setup_s and apb_req.paddr > 8'h14
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (setup_s and apb_req.paddr <= 8'h14
    and apb_req.paddr[1:0] == 2'b00 |=> !apb_rsp.pslverr) else $error("mapped refused");
  a_bitop_rd_zero: assert property (setup_s and !apb_req.pwrite
    and apb_req.paddr == tec_pkg::ADDR_BITOP |=> apb_rsp.prdata == 32'h0)
    else $error("bit op register read nonzero");
  a_port_write: assert property (wr_s and apb_req.paddr == tec_pkg::ADDR_PORT
    |=> shared_port_out[7:1] == $past(apb_req.pwdata[7:1])) else $error("port write lost");
  a_bitop_write: assert property (wr_s and apb_req.paddr == tec_pkg::ADDR_BITOP
    and apb_req.pwdata[2:0] != 3'h0
    |=> shared_port_out[$past(apb_req.pwdata[2:0])] == $past(apb_req.pwdata[3]))
    else $error("bit operation wrong");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq_a && !irq_b
    && timer_io_oe_n && shared_port_out == 8'h00) else $error("outputs not idle after reset");
endmodule
////////////////////////////////////////////////////////////////////////////
bind tec_timer tec_timer_sva u_sva (
  .core_clk        (core_clk),
  .rst_n           (rst_n),
  .clk_en          (clk_en),
  .apb_req         (apb_req),
  .apb_rsp         (apb_rsp),
  .timer_io_pin    (timer_io_pin),
  .timer_in_pin    (timer_in_pin),
  .timer_io_out    (timer_io_out),
  .timer_io_oe_n   (timer_io_oe_n),
  .shared_port_out (shared_port_out),
  .irq_a           (irq_a),
  .irq_b           (irq_b)
);

// ==== tb/tec_pin_model.sv ====
module tec_pin_model (
  input  wire logic core_clk,
  output logic      io_pin,
  output logic      in_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    io_pin = 1'b0;
    in_pin = 1'b0;
  end
  // each level is held six cycles, above the two-cycle minimum
  task automatic drive(input logic sel_b, input logic lvl);
    @(posedge core_clk);
    if (sel_b) begin
      in_pin <= lvl;
    end else begin
      io_pin <= lvl;
    end
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ==== tb/timer_event_capture_block_test.sv ====
module timer_event_capture_block_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  clk_en = 1'b1;
  tec_pkg::tec_apb_req_t req = '0;
  tec_pkg::tec_apb_rsp_t rsp;
  logic                  io_pin, in_pin, io_out, oe_n, irq_a, irq_b;
  logic [7:0]            port;
  logic [31:0]           rdata, c1;
  logic                  rerr;
  int                    mismatches = 0;
  int                    checks = 0;
  always #20 core_clk = ~core_clk;
  tec_timer uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .apb_req(req),
    .apb_rsp(rsp), .timer_io_pin(io_pin), .timer_in_pin(in_pin), .timer_io_out(io_out),
    .timer_io_oe_n(oe_n), .shared_port_out(port), .irq_a(irq_a), .irq_b(irq_b));
  tec_pin_model pins (.core_clk(core_clk), .io_pin(io_pin), .in_pin(in_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic run, ena, enb, fast);
    logic [31:0] v;
    v = '0;
    v[tec_pkg::CTRL_RUN] = run;
    v[tec_pkg::CTRL_MODE_LO] = m[0];
    v[tec_pkg::CTRL_MODE_MI] = m[1];
    v[tec_pkg::CTRL_MODE_HI] = m[2];
    v[tec_pkg::CTRL_IRQEN_A] = ena;
    v[tec_pkg::CTRL_IRQEN_B] = enb;
    v[tec_pkg::CTRL_FAST] = fast;
    return v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] cm [4] = '{3'b010, 3'b110, 3'b011, 3'b111};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(0, 8'(i * 4), 0);
      check("reset value", rdata, 0);
    end
    bus(0, 8'h18, 0);
    check("unmapped err", rerr, 1);
    check("oe idle", oe_n, 1);
    // event count, rising edges; loaded while stopped
    bus(1, tec_pkg::ADDR_COUNT, 1);
    bus(1, tec_pkg::ADDR_RCA, 5);
    bus(1, tec_pkg::ADDR_RCB, 7);
    bus(1, tec_pkg::ADDR_CTRL, ctl(0, 1, 1, 0, 0));
    pins.drive(0, 1);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("ev rise", rdata, 0);
    pins.drive(0, 0);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("ev fall ignored", rdata, 0);
    pins.drive(0, 1);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("ev reload a", rdata, 5);
    check("ev irq a", irq_a, 1);
    check("ev oe", oe_n, 1);
    bus(1, tec_pkg::ADDR_CTRL, ctl(0, 0, 1, 0, 0));
    bus(0, tec_pkg::ADDR_CTRL, 0);
    check("pend cleared", irq_a, 0);
    pins.drive(0, 0);
    pins.drive(0, 1);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("stopped", rdata, 5);
    bus(1, tec_pkg::ADDR_CTRL, ctl(1, 1, 0, 1, 0));
    pins.drive(0, 0);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("ev falling", rdata, 4);
    pins.drive(1, 1);
    bus(0, tec_pkg::ADDR_CTRL, 0);
    check("pend b", rdata[tec_pkg::CTRL_PEND_B], 1);
    check("irq b", irq_b, 1);
    pins.drive(1, 0);
    // capture edges per pin; underflow flag cleared on entry
    for (int k = 0; k < 4; k++) begin
      bus(1, tec_pkg::ADDR_CTRL, ctl(cm[k], 0, 0, 0, 1));
      pins.drive(0, 1);
      pins.drive(1, 1);
      bus(0, tec_pkg::ADDR_CTRL, 0);
      check("cap rise a", rdata[tec_pkg::CTRL_PEND_A], !cm[k][0]);
      check("cap rise b", rdata[tec_pkg::CTRL_PEND_B], !cm[k][2]);
      pins.drive(0, 0);
      pins.drive(1, 0);
      bus(0, tec_pkg::ADDR_CTRL, 0);
      check("cap pend a", rdata[tec_pkg::CTRL_PEND_A], 1);
      check("cap pend b", rdata[tec_pkg::CTRL_PEND_B], 1);
      check("cap irq masked", {irq_a, irq_b}, 0);
    end
    bus(1, tec_pkg::ADDR_CTRL, ctl(2, 0, 0, 0, 1));
    bus(1, tec_pkg::ADDR_COUNT, 32'h8000);
    pins.drive(0, 1);
    bus(0, tec_pkg::ADDR_RCA, 0);
    check("cap value", rdata < 32'h8000 && rdata > 32'h7fe0, 1);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    c1 = rdata;
    check("count below cap", c1 < 32'h7ff8, 1);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("keeps counting", rdata < c1, 1);
    bus(1, tec_pkg::ADDR_CTRL, ctl(2, 0, 1, 0, 1));
    bus(1, tec_pkg::ADDR_COUNT, 4);
    repeat (20) @(posedge core_clk);
    bus(0, tec_pkg::ADDR_CTRL, 0);
    check("cap underflow", rdata[tec_pkg::CTRL_RUN], 1);
    check("underflow irq", irq_a, 1);
    bus(1, tec_pkg::ADDR_CTRL, ctl(2, 0, 0, 0, 0));
    bus(1, tec_pkg::ADDR_COUNT, 32'h100);
    repeat (100) @(posedge core_clk);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("slow rate", rdata > 32'hf3 && rdata < 32'hf8, 1);
    // pulse width with toggle, loaded while stopped
    bus(1, tec_pkg::ADDR_CTRL, ctl(5, 0, 0, 0, 0));
    bus(1, tec_pkg::ADDR_RCA, 32'h30);
    bus(1, tec_pkg::ADDR_RCB, 32'h60);
    bus(1, tec_pkg::ADDR_COUNT, 0);
    bus(1, tec_pkg::ADDR_CTRL, ctl(5, 1, 0, 0, 0));
    repeat (12) @(posedge core_clk);
    bus(0, tec_pkg::ADDR_COUNT, 0);
    check("pw first a", rdata > 32'h28 && rdata <= 32'h30, 1);
    bus(0, tec_pkg::ADDR_CTRL, 0);
    check("pw pend a", rdata[tec_pkg::CTRL_PEND_A], 1);
    check("pw pend b", rdata[tec_pkg::CTRL_PEND_B], 0);
    check("pw oe", oe_n, 0);
    check("pw toggle out", io_out, 1);
    bus(1, tec_pkg::ADDR_CTRL, ctl(4, 0, 0, 0, 0));
    bus(1, tec_pkg::ADDR_PORT, 32'ha4);
    check("pw no toggle oe", oe_n, 1);
    bus(1, tec_pkg::ADDR_BITOP, 32'h0b);
    bus(1, tec_pkg::ADDR_BITOP, 32'h05);
    bus(0, tec_pkg::ADDR_PORT, 0);
    check("port bit ops", rdata, 32'h8c);
    check("port pins", port, 8'h8c);
    tally_and_finish;
  end
  initial begin
    #400000;
    mismatches++;
    tally_and_finish;
  end
endmodule
